// File: design/sbra_device.sv
// Device end: message decode, register bridge, ports, framer clock.
// Assumes sbra_pkg and sbra_link_if; register file sits on user side.
// Contract
// - Eight rx, eight tx channels, sixteen ports
// - Write: page message, then data message
// - Page kept between accesses
// - Host block slice even, at most sixteen
// - Two bytes direct, longer auto-increments
// - Wide space: four-byte slices, even address
// - Wide space bytes reversed, address plus two
// - Read: page message, then value request
// - Reads return two bytes, upper half at odd wide address, else lower
// - Manager waits for reply before next request
// - Newest pending request wins
// - Firmware access needs fast processor clock
// - Bus component reset before chip reset
// - Channel live needs local and port enable
// - Channel enables cleared without main clock
// - Drive clock only as active framer
// - Framer roots: two supported frequencies
// - Gear ten equals root, halving below
// - Pause, resume, remove by port or channel; SUB_ACT, SUB_DEACT, SUB_REMOVE match channel number only
// - Main and async referenced rates coexist
// - Port number per channel programmable
// - Pending changes at boundary two slots later; framer change applies at SUB_RECONF decode
`timescale 1ns/1ps
module sbra_device import sbra_pkg::*; #(
	parameter int SF_EDGES = SLOT_EDGES * SF_SLOTS
) (
	input  wire logic                    sys_clk_in,
	input  wire logic                    reset_n_in,
	sbra_link_if.dev                     link,
	input  wire logic [NCHAN-1:0]        chan_enable_in,
	input  wire logic [NCHAN*PN_W-1:0]   chan_port_in,
	input  wire logic [NCHAN*RATE_W-1:0] chan_rate_in,
	input  wire logic                    main_clock_ok_in,
	input  wire logic                    root_sel_in,
	output logic      [NCHAN-1:0]        chan_active_out,
	output logic      [NCHAN-1:0]        chan_async_out,
	output logic      [NPORT-1:0]        port_status_out,
	output logic                         framer_out,
	output logic      [3:0]              gear_out,
	output logic                         bus_reset_out,
	output logic                         reg_wr_out,
	output logic                         reg_wide_out,
	output logic                         reg_rd_out,
	output logic      [23:0]             reg_addr_out,
	output logic      [31:0]             reg_wr_data_out,
	input  wire logic [31:0]             reg_rd_data_in
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_RX = 2'b01, ST_TX = 2'b10
	} sbra_st_e;

	// --------------------------------------------------------------
	// Link and register bridge state
	// --------------------------------------------------------------
	sbra_st_e          st_q, st_d;
	logic [2:0]        ck_q, ck_d;
	logic [1:0]        dt_q, dt_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic [MSG_W-1:0]  sh_q, sh_d, msg_q, msg_d;
	logic              msgv_q, msgv_d, pend_q, pend_d, rdw_q, rdw_d;
	logic              half_q, half_d, odd_q, odd_d;
	logic [1:0]        turn_q, turn_d;
	logic [7:0]        tid_q, tid_d;
	logic [15:0]       page_q, page_d, rdat_q, rdat_d, wlow_q, wlow_d;
	logic [23:0]       wa_q, wa_d, a;
	logic [3:0]        wleft_q, wleft_d;
	logic              wr_q, wr_d, wide_q, wide_d, rd_q, rd_d;
	logic [23:0]       addr_q, addr_d;
	logic [31:0]       wdat_q, wdat_d;
	logic              rise, fall, wv;
	logic [15:0]       w;
	sbra_op_e          op;

	assign rise = ck_q[1] & ~ck_q[2];
	assign fall = ~ck_q[1] & ck_q[2];
	assign op   = sbra_op_e'(msg_q[OP_HI:OP_LO]);
	assign w    = msg_q[15:0];

	always_comb begin
		st_d = st_q;
		ck_d = {ck_q[1:0], link.bus_clock_pin};
		dt_d = {dt_q[0], link.bus_data_pin};
		cnt_d = cnt_q;
		sh_d = sh_q;
		msg_d = msg_q;
		msgv_d = 1'b0;
		pend_d = pend_q;
		rdw_d = rd_q;
		half_d = half_q;
		odd_d = odd_q;
		turn_d = turn_q;
		tid_d = tid_q;
		page_d = page_q;
		rdat_d = rdat_q;
		wlow_d = wlow_q;
		wa_d = wa_q;
		wleft_d = wleft_q;
		wr_d = 1'b0;
		wide_d = 1'b0;
		rd_d = 1'b0;
		addr_d = addr_q;
		wdat_d = wdat_q;
		a = {page_q, msg_q[LO_HI:LO_LO]};
		wv = 1'b0;
		unique case (st_q)
			ST_IDLE: begin
				if (rise && dt_q[1]) begin
					st_d = ST_RX;
					cnt_d = '0;
				end else if (pend_q && fall && turn_q == 2'(TURN_EDGES)) begin
					st_d = ST_TX;
					sh_d = {1'b1, tid_q, rdat_q, 7'h00};
					cnt_d = '0;
					pend_d = 1'b0;
				end else if (pend_q && rise && turn_q != 2'(TURN_EDGES)) begin
					turn_d = turn_q + 2'h1;
				end
			end
			ST_RX: begin
				if (rise) begin
					sh_d = {sh_q[MSG_W-2:0], dt_q[1]};
					cnt_d = cnt_q + CNT_W'(1);
					if (cnt_q == CNT_W'(MSG_W - 1)) begin
						msgv_d = 1'b1;
						msg_d = {sh_q[MSG_W-2:0], dt_q[1]};
						st_d = ST_IDLE;
					end
				end
			end
			ST_TX: begin
				if (rise && cnt_q == CNT_W'(RPL_W)) begin
					st_d = ST_IDLE;
				end else if (fall && cnt_q != CNT_W'(RPL_W)) begin
					sh_d = {sh_q[MSG_W-2:0], 1'b0};
					cnt_d = cnt_q + CNT_W'(1);
				end
			end
			default: st_d = ST_IDLE;
		endcase
		if (rdw_q) begin
			rdat_d = half_q ? reg_rd_data_in[31:16] : reg_rd_data_in[15:0];
			pend_d = 1'b1;
			turn_d = 2'h0;
		end
		if (msgv_q) begin
			unique case (op)
				OP_PAGE: page_d = w;
				OP_DATA: begin
					wleft_d = 4'(msg_q[SZ_HI:SZ_LO+1]) - 4'h1;
					odd_d = 1'b0;
					wv = 1'b1;
				end
				OP_CONT: begin
					if (wleft_q != 4'h0) begin
						wleft_d = wleft_q - 4'h1;
						a = wa_q;
						wv = 1'b1;
					end
				end
				OP_REQ: begin
					tid_d = msg_q[TID_HI:TID_LO];
					half_d = (a >= WIDE_BASE) && a[0];
					addr_d = (a >= WIDE_BASE) ? {a[23:1], 1'b0} : a;
					rd_d = 1'b1;
					pend_d = 1'b0;
				end
				OP_NEXT: begin
					if (sbra_sub_e'(msg_q[SUB_HI:SUB_LO]) == SUB_RESET) begin
						page_d = 16'h0000;
						pend_d = 1'b0;
						wleft_d = 4'h0;
					end
				end
				default: ;
			endcase
		end
		if (wv) begin
			if (a < WIDE_BASE) begin
				wr_d = 1'b1;
				addr_d = a;
				wdat_d = {16'h0000, w};
				wa_d = a + 24'h000001;
			end else if (!odd_d) begin
				wlow_d = {w[7:0], w[15:8]};
				odd_d = 1'b1;
				wa_d = a;
			end else begin
				wr_d = 1'b1;
				wide_d = 1'b1;
				addr_d = a;
				wdat_d = {w[7:0], w[15:8], wlow_q};
				wa_d = a + 24'h000002;
				odd_d = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			st_q <= ST_IDLE;
			ck_q <= 3'h0;
			dt_q <= 2'h0;
			cnt_q <= '0;
			sh_q <= '0;
			msg_q <= '0;
			msgv_q <= 1'b0;
			pend_q <= 1'b0;
			rdw_q <= 1'b0;
			half_q <= 1'b0;
			odd_q <= 1'b0;
			turn_q <= 2'h0;
			tid_q <= 8'h00;
			page_q <= 16'h0000;
			rdat_q <= 16'h0000;
			wlow_q <= 16'h0000;
			wa_q <= 24'h000000;
			wleft_q <= 4'h0;
			wr_q <= 1'b0;
			wide_q <= 1'b0;
			rd_q <= 1'b0;
			addr_q <= 24'h000000;
			wdat_q <= 32'h00000000;
		end else begin
			st_q <= st_d;
			ck_q <= ck_d;
			dt_q <= dt_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			msg_q <= msg_d;
			msgv_q <= msgv_d;
			pend_q <= pend_d;
			rdw_q <= rdw_d;
			half_q <= half_d;
			odd_q <= odd_d;
			turn_q <= turn_d;
			tid_q <= tid_d;
			page_q <= page_d;
			rdat_q <= rdat_d;
			wlow_q <= wlow_d;
			wa_q <= wa_d;
			wleft_q <= wleft_d;
			wr_q <= wr_d;
			wide_q <= wide_d;
			rd_q <= rd_d;
			addr_q <= addr_d;
			wdat_q <= wdat_d;
		end
	end

	assign link.dat_dev_o  = sh_q[MSG_W-1];
	assign link.dat_dev_oe = (st_q == ST_TX);
	assign reg_wr_out      = wr_q;
	assign reg_wide_out    = wide_q;
	assign reg_rd_out      = rd_q;
	assign reg_addr_out    = addr_q;
	assign reg_wr_data_out = wdat_q;

	// --------------------------------------------------------------
	// Port, channel and clocking state
	// --------------------------------------------------------------
	logic [NPORT-1:0] conn_q, conn_d, act_q, act_d;
	logic [NPORT-1:0] pon_q, pon_d, poff_q, poff_d, prm_q, prm_d;
	logic [NPORT-1:0] stat_q, stat_d, cm;
	logic [7:0]       cn_q [NPORT];
	logic [7:0]       cn_d [NPORT];
	logic [NCHAN-1:0] cact_q, cact_d, casy_q, casy_d;
	logic [3:0]       gear_q, gear_d, pg_q, pg_d;
	logic             pgv_q, pgv_d, pfv_q, pfv_d, pf_q, pf_d;
	logic             arm_q, arm_d, fr_q, fr_d, bclk_q, bclk_d;
	logic             brst_q, brst_d;
	logic [15:0]      wt_q, wt_d, sf_q, sf_d, div_q, div_d;
	logic [31:0]      half;
	logic [PN_W-1:0]  pn;
	logic [PN_W-1:0]  mp;

	always_comb begin
		conn_d = conn_q;
		act_d = act_q;
		pon_d = pon_q;
		poff_d = poff_q;
		prm_d = prm_q;
		cn_d = cn_q;
		gear_d = gear_q;
		pg_d = pg_q;
		pgv_d = pgv_q;
		pfv_d = pfv_q;
		pf_d = pf_q;
		arm_d = arm_q;
		fr_d = fr_q;
		brst_d = 1'b0;
		wt_d = wt_q;
		sf_d = sf_q;
		div_d = div_q;
		bclk_d = bclk_q;
		pn = '0;
		mp = msg_q[PN_HI:PN_LO];
		for (int p = 0; p < NPORT; p++) begin
			cm[p] = conn_q[p] && cn_q[p] == msg_q[CN_HI:CN_LO];
		end
		if (msgv_q) begin
			unique case (op)
				OP_CONN: begin
					conn_d[mp] = 1'b1;
					act_d[mp] = 1'b0;
					cn_d[mp] = msg_q[CN_HI:CN_LO];
				end
				OP_DISC: begin
					conn_d[mp] = 1'b0;
					act_d[mp] = 1'b0;
				end
				OP_NEXT: begin
					unique case (sbra_sub_e'(msg_q[SUB_HI:SUB_LO]))
						SUB_ACT:    pon_d = pon_q | cm;
						SUB_DEACT:  poff_d = poff_q | cm;
						SUB_REMOVE: prm_d = prm_q | cm;
						SUB_GEAR: begin
							pgv_d = 1'b1;
							pg_d = msg_q[3:0];
						end
						SUB_FRAMER: begin
							pfv_d = 1'b1;
							pf_d = msg_q[0];
						end
						SUB_RECONF: begin
							arm_d = 1'b1;
							wt_d = 16'h0000;
							if (pfv_q) begin
								fr_d = pf_q;
								pfv_d = 1'b0;
							end
						end
						SUB_RESET: begin
							conn_d = '0;
							act_d = '0;
							pon_d = '0;
							poff_d = '0;
							prm_d = '0;
							pgv_d = 1'b0;
							pfv_d = 1'b0;
							arm_d = 1'b0;
							fr_d = 1'b0;
							brst_d = 1'b1;
						end
						default: ;
					endcase
				end
				default: ;
			endcase
		end
		if (rise) begin
			sf_d = (sf_q == 16'(SF_EDGES - 1)) ? 16'h0000 : sf_q + 16'h0001;
			if (arm_q && wt_q != 16'hFFFF) begin
				wt_d = wt_q + 16'h0001;
			end
			if (arm_q && sf_q == 16'(SF_EDGES - 1) && wt_q >= 16'(MIN_EDGES)) begin
				act_d = (act_q | (pon_q & conn_q)) & ~poff_q & ~prm_q;
				conn_d = conn_q & ~prm_q;
				if (pgv_q) begin
					gear_d = pg_q;
				end
				pon_d = '0;
				poff_d = '0;
				prm_d = '0;
				pgv_d = 1'b0;
				arm_d = 1'b0;
			end
		end
		// Two root choices only; halving per gear below the top
		half = 32'(root_sel_in ? HALF_B : HALF_A) << (GEAR_TOP - gear_q);
		if (fr_q && gear_q != GEAR_STOP) begin
			if (32'(div_q) >= half - 32'h1) begin
				div_d = 16'h0000;
				bclk_d = ~bclk_q;
			end else begin
				div_d = div_q + 16'h0001;
			end
		end
		for (int i = 0; i < NCHAN; i++) begin
			pn = chan_port_in[i*PN_W +: PN_W];
			cact_d[i] = chan_enable_in[i] && conn_q[pn] && act_q[pn]
				&& main_clock_ok_in;
			casy_d[i] = cact_d[i] && chan_rate_in[i*RATE_W + RATE_ASYNC_BIT];
		end
		stat_d = conn_q & act_q;
	end

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			conn_q <= '0;
			act_q <= '0;
			pon_q <= '0;
			poff_q <= '0;
			prm_q <= '0;
			stat_q <= '0;
			cact_q <= '0;
			casy_q <= '0;
			for (int p = 0; p < NPORT; p++) begin
				cn_q[p] <= 8'h00;
			end
			gear_q <= GEAR_TOP;
			pg_q <= GEAR_TOP;
			pgv_q <= 1'b0;
			pfv_q <= 1'b0;
			pf_q <= 1'b0;
			arm_q <= 1'b0;
			fr_q <= 1'b0;
			brst_q <= 1'b0;
			wt_q <= 16'h0000;
			sf_q <= 16'h0000;
			div_q <= 16'h0000;
			bclk_q <= 1'b0;
		end else begin
			conn_q <= conn_d;
			act_q <= act_d;
			pon_q <= pon_d;
			poff_q <= poff_d;
			prm_q <= prm_d;
			stat_q <= stat_d;
			cact_q <= cact_d;
			casy_q <= casy_d;
			cn_q <= cn_d;
			gear_q <= gear_d;
			pg_q <= pg_d;
			pgv_q <= pgv_d;
			pfv_q <= pfv_d;
			pf_q <= pf_d;
			arm_q <= arm_d;
			fr_q <= fr_d;
			brst_q <= brst_d;
			wt_q <= wt_d;
			sf_q <= sf_d;
			div_q <= div_d;
			bclk_q <= bclk_d;
		end
	end

	assign link.clk_dev_o  = bclk_q;
	assign link.clk_dev_oe = fr_q;
	assign chan_active_out = cact_q;
	assign chan_async_out  = casy_q;
	assign port_status_out = stat_q;
	assign framer_out      = fr_q;
	assign gear_out        = gear_q;
	assign bus_reset_out   = brst_q;
endmodule // sbra_device

// File: design/sbra_link_if.sv
// Two-wire link between the manager end and the device end.
// Assumes no other driver; an undriven wire reads low.
`timescale 1ns/1ps
interface sbra_link_if;
	logic clk_mgr_o;
	logic clk_mgr_oe;
	logic clk_dev_o;
	logic clk_dev_oe;
	logic dat_mgr_o;
	logic dat_mgr_oe;
	logic dat_dev_o;
	logic dat_dev_oe;
	logic bus_clock_pin;
	logic bus_data_pin;

	// --------------------------------------------------------------
	// Wire resolution
	// --------------------------------------------------------------
	assign bus_clock_pin = (clk_mgr_oe & clk_mgr_o) | (clk_dev_oe & clk_dev_o);
	assign bus_data_pin  = (dat_mgr_oe & dat_mgr_o) | (dat_dev_oe & dat_dev_o);

	modport dev (
		input  bus_clock_pin, bus_data_pin,
		output clk_dev_o, clk_dev_oe, dat_dev_o, dat_dev_oe
	);
	modport mgr (
		input  bus_clock_pin, bus_data_pin,
		output clk_mgr_o, clk_mgr_oe, dat_mgr_o, dat_mgr_oe
	);
endinterface

// File: design/sbra_manager.sv
// Manager end: sends messages, collects replies, drives clock.
// Assumes sbra_pkg and sbra_link_if; commands come from user logic.
`timescale 1ns/1ps
module sbra_manager import sbra_pkg::*; (
	input  wire logic        sys_clk_in,
	input  wire logic        reset_n_in,
	sbra_link_if.mgr         link,
	input  wire logic        cmd_valid_in,
	input  wire logic [31:0] cmd_word_in,
	output logic             cmd_ready_out,
	input  wire logic        fw_clock_ok_in,
	input  wire logic [3:0]  gear_in,
	output logic             rpl_valid_out,
	output logic [23:0]      rpl_word_out
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_TX = 2'b01, ST_WAIT = 2'b11, ST_RX = 2'b10
	} sbra_mst_e;

	// --------------------------------------------------------------
	// Sender, receiver and clock driver
	// --------------------------------------------------------------
	sbra_mst_e        st_q, st_d;
	logic [2:0]       ck_q, ck_d;
	logic [1:0]       dt_q, dt_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [MSG_W:0]   sh_q, sh_d;
	logic [RPL_W-1:0] rw_q, rw_d;
	logic             rv_q, rv_d, drv_q, drv_d, pf_q, pf_d;
	logic             req_q, req_d, nx_q, nx_d, bclk_q, bclk_d;
	logic [15:0]      div_q, div_d, pg_q, pg_d;
	logic [31:0]      half, c;
	logic [4:0]       sz;
	logic             rise, fall, take, fw;
	sbra_op_e         op;

	assign rise = ck_q[1] & ~ck_q[2];
	assign fall = ~ck_q[1] & ck_q[2];
	assign op   = sbra_op_e'(cmd_word_in[OP_HI:OP_LO]);
	assign fw   = (op == OP_DATA) || (op == OP_CONT) || (op == OP_REQ);
	assign take = cmd_valid_in && st_q == ST_IDLE && fall
		&& (fw_clock_ok_in || !fw);

	always_comb begin
		st_d = st_q;
		ck_d = {ck_q[1:0], link.bus_clock_pin};
		dt_d = {dt_q[0], link.bus_data_pin};
		cnt_d = cnt_q;
		sh_d = sh_q;
		rw_d = rw_q;
		rv_d = 1'b0;
		drv_d = drv_q;
		pf_d = pf_q;
		req_d = req_q;
		nx_d = nx_q;
		div_d = div_q;
		pg_d = pg_q;
		bclk_d = bclk_q;
		c = cmd_word_in;
		sz = cmd_word_in[SZ_HI:SZ_LO] & 5'h1E;
		if (sz > MAX_SLICE) begin
			sz = MAX_SLICE;
		end
		if (op == OP_DATA) begin
			if ({pg_q, cmd_word_in[LO_HI:LO_LO]} >= WIDE_BASE) begin
				sz = (sz[4:2] == 3'h0) ? 5'h04 : {sz[4:2], 2'b00};
			end
			c[SZ_HI:SZ_LO] = sz;
		end
		unique case (st_q)
			ST_IDLE: begin
				if (take) begin
					st_d = ST_TX;
					sh_d = {1'b1, c};
					cnt_d = '0;
					req_d = (op == OP_REQ);
					nx_d = (op == OP_NEXT) && c[SUB_HI:SUB_LO] == SUB_RECONF;
					if (op == OP_PAGE) begin
						pg_d = c[15:0];
					end
					if (op == OP_NEXT && c[SUB_HI:SUB_LO] == SUB_FRAMER) begin
						pf_d = c[0];
					end
					if (op == OP_NEXT && c[SUB_HI:SUB_LO] == SUB_RESET) begin
						pf_d = 1'b0;
						pg_d = 16'h0000;
					end
				end
			end
			ST_TX: begin
				if (fall) begin
					if (cnt_q == CNT_W'(MSG_W)) begin
						st_d = req_q ? ST_WAIT : ST_IDLE;
						if (nx_q) begin
							drv_d = !pf_q;
						end
					end else begin
						sh_d = {sh_q[MSG_W-1:0], 1'b0};
						cnt_d = cnt_q + CNT_W'(1);
					end
				end
			end
			ST_WAIT: begin
				if (rise && dt_q[1]) begin
					st_d = ST_RX;
					cnt_d = '0;
				end
			end
			ST_RX: begin
				if (rise) begin
					rw_d = {rw_q[RPL_W-2:0], dt_q[1]};
					cnt_d = cnt_q + CNT_W'(1);
					if (cnt_q == CNT_W'(RPL_W - 1)) begin
						rv_d = 1'b1;
						st_d = ST_IDLE;
					end
				end
			end
		endcase
		half = 32'(HALF_A) << (GEAR_TOP - gear_in);
		if (drv_q && gear_in != GEAR_STOP) begin
			if (32'(div_q) >= half - 32'h1) begin
				div_d = 16'h0000;
				bclk_d = ~bclk_q;
			end else begin
				div_d = div_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			st_q <= ST_IDLE;
			ck_q <= 3'h0;
			dt_q <= 2'h0;
			cnt_q <= '0;
			sh_q <= '0;
			rw_q <= '0;
			rv_q <= 1'b0;
			drv_q <= 1'b1;
			pf_q <= 1'b0;
			req_q <= 1'b0;
			nx_q <= 1'b0;
			div_q <= 16'h0000;
			pg_q <= 16'h0000;
			bclk_q <= 1'b0;
		end else begin
			st_q <= st_d;
			ck_q <= ck_d;
			dt_q <= dt_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			rw_q <= rw_d;
			rv_q <= rv_d;
			drv_q <= drv_d;
			pf_q <= pf_d;
			req_q <= req_d;
			nx_q <= nx_d;
			div_q <= div_d;
			pg_q <= pg_d;
			bclk_q <= bclk_d;
		end
	end

	assign link.clk_mgr_o  = bclk_q;
	assign link.clk_mgr_oe = drv_q;
	assign link.dat_mgr_o  = (st_q == ST_TX) & sh_q[MSG_W];
	assign link.dat_mgr_oe = (st_q == ST_IDLE) || (st_q == ST_TX);
	assign cmd_ready_out   = take;
	assign rpl_valid_out   = rv_q;
	assign rpl_word_out    = rw_q;
endmodule // sbra_manager

// File: design/sbra_pkg.sv
// Shared constants for the serial bus register access bridge.
// Assumes both link ends and the bench compile this package first.
package sbra_pkg;
	// --------------------------------------------------------------
	// Message layout
	// --------------------------------------------------------------
	localparam int MSG_W   = 32;
	localparam int RPL_W   = 24;
	localparam int NPORT   = 16;
	localparam int NCHAN   = 16;
	localparam int PN_W    = 4;
	localparam int RATE_W  = 4;
	localparam int CNT_W   = 6;
	localparam int OP_HI   = 31;
	localparam int OP_LO   = 29;
	localparam int SZ_HI   = 28;
	localparam int SZ_LO   = 24;
	localparam int SUB_HI  = 27;
	localparam int SUB_LO  = 24;
	localparam int LO_HI   = 23;
	localparam int LO_LO   = 16;
	localparam int TID_HI  = 15;
	localparam int TID_LO  = 8;
	localparam int PN_HI   = 11;
	localparam int PN_LO   = 8;
	localparam int CN_HI   = 7;
	localparam int CN_LO   = 0;
	localparam int RATE_ASYNC_BIT = 3;
	localparam logic [23:0] WIDE_BASE  = 24'h003000;
	localparam logic [4:0]  MAX_SLICE  = 5'h10;
	localparam logic [3:0]  GEAR_TOP   = 4'hA;
	localparam logic [3:0]  GEAR_STOP  = 4'h0;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0, OP_PAGE = 3'h1, OP_DATA = 3'h2, OP_CONT = 3'h3,
		OP_REQ  = 3'h4, OP_CONN = 3'h5, OP_DISC = 3'h6, OP_NEXT = 3'h7
	} sbra_op_e;

	typedef enum logic [3:0] {
		SUB_ACT    = 4'h0, SUB_DEACT  = 4'h1, SUB_REMOVE = 4'h2,
		SUB_GEAR   = 4'h3, SUB_FRAMER = 4'h4, SUB_RECONF = 4'h5,
		SUB_RESET  = 4'h6
	} sbra_sub_e;

	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int SYS_HZ     = 200000000;
	localparam int ROOT_A_HZ  = 24576000;
	localparam int ROOT_B_HZ  = 22579200;
	localparam int HALF_A_RAW = SYS_HZ / (2 * ROOT_A_HZ);
	localparam int HALF_B_RAW = SYS_HZ / (2 * ROOT_B_HZ);
	localparam int HALF_A     = (HALF_A_RAW < 1) ? 1 : HALF_A_RAW;
	localparam int HALF_B     = (HALF_B_RAW < 1) ? 1 : HALF_B_RAW;
	localparam int SLOT_EDGES = 4;
	localparam int SF_SLOTS   = 1536;
	localparam int MIN_SLOTS  = 2;
	localparam int MIN_EDGES  = MIN_SLOTS * SLOT_EDGES;
	localparam int TURN_EDGES = 2;
endpackage

// File: sim/sbra_link_sva.sv
// Link checker: wire ownership and reply framing on the link.
// Assumes it sits beside the interface that joins both ends.
`timescale 1ns/1ps
module sbra_link_sva (
	input wire logic	sys_clk_in,
	input wire logic	reset_n_in,
	input wire logic	clk_mgr_oe,
	input wire logic	clk_dev_oe,
	input wire logic	dat_mgr_oe,
	input wire logic	dat_dev_o,
	input wire logic	dat_dev_oe
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!reset_n_in);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	clk_excl_a: assert property (!(clk_mgr_oe && clk_dev_oe))
		else $error("both ends drive the clock");
	dev_idle_a: assert property ($rose(reset_n_in) |-> !clk_dev_oe && !dat_dev_oe)
		else $error("device drives link after reset");
	mgr_clk_a: assert property ($rose(reset_n_in) |-> clk_mgr_oe)
		else $error("manager not driving clock after reset");
	dat_excl_a: assert property (dat_dev_oe |-> !dat_mgr_oe)
		else $error("both ends drive data");
	turn_gap_a: assert property ($rose(dat_dev_oe) |-> $past(dat_mgr_oe, 2) == 1'b0)
		else $error("reply without turnaround");
	start_bit_a: assert property ($rose(dat_dev_oe) |-> dat_dev_o)
		else $error("reply start bit low");
	reply_min_a: assert property ($rose(dat_dev_oe) |-> dat_dev_oe [*8])
		else $error("reply too short");
	reply_max_a: assert property ($rose(dat_dev_oe) |-> ##[1:1000] !dat_dev_oe)
		else $error("reply never ends");
	reply_due_a: assert property ($fell(dat_mgr_oe) |-> ##[1:300] $rose(dat_dev_oe))
		else $error("no reply to request");
	cover property ($rose(dat_dev_oe));
	cover property ($fell(dat_mgr_oe));
	cover property ($fell(dat_dev_oe) ##1 clk_mgr_oe);
endmodule // sbra_link_sva

// File: sim/test_serial_bus_register_access.sv
// Bench: both link ends, a register file model and a link checker.
// Assumes sbra_pkg, the link interface and both ends are compiled.
`timescale 1ns/1ps
module test_serial_bus_register_access import sbra_pkg::*;;
	logic		sys_clk_in = 1'b0;
	logic		reset_n_in = 1'b0;
	logic		brst_seen = 1'b0;
	logic		cmd_valid_in, cmd_ready_out, rpl_valid_out;
	logic		main_clock_ok_in, framer_out, bus_reset_out;
	logic		reg_wr_out, reg_wide_out, reg_rd_out;
	logic [3:0]	gear_out;
	logic [15:0]	chan_enable_in, chan_active_out, chan_async_out;
	logic [15:0]	port_status_out, salt;
	logic [23:0]	rpl_word_out, reg_addr_out;
	logic [31:0]	cmd_word_in, reg_wr_data_out;
	logic [31:0]	reg_rd_data_in = 32'h0;
	logic [31:0]	rng = 32'hD9D2;
	logic [63:0]	chan_port_in, chan_rate_in;
	logic [56:0]	exp_q[$];
	int		n_errors, total_checks, page;
	sbra_link_if link();
	sbra_device #(.SF_EDGES(16)) sbra_device_inst (.sys_clk_in,
		.reset_n_in, .link(link), .chan_enable_in, .chan_port_in,
		.chan_rate_in, .main_clock_ok_in, .root_sel_in(1'b0),
		.chan_active_out, .chan_async_out, .port_status_out, .framer_out,
		.gear_out, .bus_reset_out, .reg_wr_out, .reg_wide_out, .reg_rd_out,
		.reg_addr_out, .reg_wr_data_out, .reg_rd_data_in);
	sbra_manager sbra_manager_inst (.sys_clk_in, .reset_n_in, .link(link),
		.cmd_valid_in, .cmd_word_in, .cmd_ready_out,
		.fw_clock_ok_in(1'b1),
		.gear_in(GEAR_TOP), .rpl_valid_out, .rpl_word_out);
	sbra_link_sva sbra_link_sva_inst (.sys_clk_in, .reset_n_in,
		.clk_mgr_oe(link.clk_mgr_oe), .clk_dev_oe(link.clk_dev_oe),
		.dat_mgr_oe(link.dat_mgr_oe), .dat_dev_o(link.dat_dev_o),
		.dat_dev_oe(link.dat_dev_oe));
	always #2.5 sys_clk_in = ~sys_clk_in;
	// ----------------------------------------
	// Helpers and register file model
	// ----------------------------------------
	function logic [15:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[15:0];
	endfunction
	function logic [31:0] rf(input logic [23:0] a);
		logic [23:0] k;
		k = (a >= WIDE_BASE) ? {a[23:1], 1'b0} : a;
		return {k[15:0] ^ 16'h5A5A, k[15:0] ^ salt};
	endfunction
	function logic [31:0] nx(input sbra_sub_e s, input logic [7:0] c);
		return {OP_NEXT, 1'b0, s, 16'h0, c};
	endfunction
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [63:0] got, input logic [63:0] want);
		total_checks++;
		if (got !== want) begin
			n_errors++;
			$display("unexpected at %0t got %h want %h", $time, got, want);
		end
	endtask
	task stall;
		n_errors++;
		$display("unexpected stall at %0t", $time);
		close_out;
	endtask
	always @(posedge sys_clk_in) begin
		reg_rd_data_in <= (reg_rd_out === 1'b1) ? rf(reg_addr_out) : ~reg_rd_data_in;
		if (bus_reset_out === 1'b1)
			brst_seen <= 1'b1;
		if (reg_wr_out === 1'b1) begin
			if (exp_q.size() == 0)
				chk(1, 0);
			else
				chk({reg_wide_out, reg_addr_out, reg_wide_out ? reg_wr_data_out[31:16] : 16'h0, reg_wr_data_out[15:0]}, exp_q.pop_front());
		end
	end
	task send(input logic [31:0] w);
		int i;
		cmd_valid_in <= 1'b1;
		cmd_word_in <= w;
		for (i = 0; i < 5000; i++) begin
			@(negedge sys_clk_in);
			if (cmd_ready_out === 1'b1)
				break;
		end
		if (i == 5000)
			stall();
		@(posedge sys_clk_in);
		cmd_valid_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask
	task setpg(input logic [23:0] a);
		if (a[23:8] != page[15:0]) begin
			send({OP_PAGE, 13'h0, a[23:8]});
			page = int'(a[23:8]);
		end
	endtask
	task wr(input logic [23:0] a, input int nw);
		logic [15:0] w[8];
		int k;
		for (k = 0; k < nw; k++) begin
			w[k] = xs();
			if (a < WIDE_BASE)
				exp_q.push_back({1'b0, a + 24'(k), 16'h0, w[k]});
			else if (k % 2 == 1)
				exp_q.push_back({1'b1, a + 24'(k - 1), w[k][7:0], w[k][15:8], w[k-1][7:0], w[k-1][15:8]});
		end
		setpg(a);
		send({OP_DATA, 5'(2 * nw), a[7:0], w[0]});
		for (k = 1; k < nw; k++)
			send({OP_CONT, 13'h0, w[k]});
		for (k = 0; k < 3000 && exp_q.size() != 0; k++)
			@(posedge sys_clk_in);
		chk(exp_q.size(), 0);
		if (exp_q.size() != 0)
			stall();
		$display("write of %0d words at %h done", nw, a);
	endtask
	task rd(input logic [23:0] a, input logic [7:0] tid);
		logic [31:0] d;
		int i;
		d = rf(a);
		setpg(a);
		send({OP_REQ, 5'h0, a[7:0], tid, 8'h0});
		for (i = 0; i < 3000 && rpl_valid_out !== 1'b1; i++)
			@(negedge sys_clk_in);
		if (i == 3000)
			stall();
		chk(rpl_word_out, {tid, (a >= WIDE_BASE && a[0]) ? d[31:16] : d[15:0]});
		$display("read at %h done", a);
		@(posedge sys_clk_in);
	endtask
	task settle(input logic [15:0] ps);
		logic [15:0] act;
		int i;
		for (i = 0; i < 3000 && port_status_out !== ps; i++)
			@(posedge sys_clk_in);
		if (i == 3000)
			stall();
		repeat (2) @(posedge sys_clk_in);
		act = chan_enable_in & {<<{ps}};
		chk(port_status_out, ps);
		chk(chan_active_out, act);
		chk(chan_async_out, act & 16'h0200);
		$display("channel state %h done", ps);
	endtask
	task reset_pulse;
		reset_n_in <= 1'b0;
		repeat (20) @(posedge sys_clk_in);
		reset_n_in <= 1'b1;
		page = 0;
		@(posedge sys_clk_in);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		cmd_valid_in = 1'b0;
		cmd_word_in = 32'h0;
		main_clock_ok_in = 1'b1;
		salt = xs();
		chan_enable_in = 16'h0208 | xs();
		chan_port_in = 64'h0123456789ABCDEF;
		chan_rate_in = 64'h0000008000000000;
		reset_pulse();
		chk({framer_out, gear_out}, {1'b0, GEAR_TOP});
		wr(24'h000345, 1);
		wr(24'h000310, 8);
		rd(24'h000316, 8'h5C);
		wr(24'h003000, 8);
		rd(24'h003004, 8'h21);
		rd(24'h003005, 8'h22);
		send({OP_CONN, 17'h0, 4'hC, 8'h03});
		send({OP_CONN, 17'h0, 4'h6, 8'h09});
		send(nx(SUB_ACT, 8'h03));
		send(nx(SUB_ACT, 8'h09));
		send(nx(SUB_GEAR, 8'h09));
		send(nx(SUB_RECONF, 8'h00));
		settle(16'h1040);
		chk(gear_out, 4'h9);
		chan_enable_in <= 16'h0000;
		@(posedge sys_clk_in);
		main_clock_ok_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		chk(chan_active_out, 16'h0);
		main_clock_ok_in <= 1'b1;
		@(posedge sys_clk_in);
		chan_enable_in <= 16'h0208 | xs();
		send(nx(SUB_DEACT, 8'h03));
		send(nx(SUB_RECONF, 8'h00));
		settle(16'h0040);
		send(nx(SUB_REMOVE, 8'h09));
		send(nx(SUB_RECONF, 8'h00));
		settle(16'h0000);
		send({OP_CONN, 17'h0, 4'hC, 8'h03});
		send(nx(SUB_ACT, 8'h03));
		send(nx(SUB_RECONF, 8'h00));
		settle(16'h1000);
		send({OP_DISC, 17'h0, 4'hC, 8'h03});
		settle(16'h0000);
		send(nx(SUB_RESET, 8'h00));
		repeat (400) @(posedge sys_clk_in);
		chk(brst_seen, 1'b1);
		reset_pulse();
		rd(24'h000012, 8'h7E);
		close_out;
	end
endmodule // test_serial_bus_register_access
